// ### common/delay_sched_pkg.sv
// package: register map, field layouts, reset values and types of the delay trigger scheduler
package delay_sched_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam int NUM_PRE = 2;
	// register word offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MOD = 8'h04;
	localparam logic [7:0] OFF_INTERRUPT_DELAY_VALUE = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_CLEAR = 8'h14;
	localparam logic [7:0] OFF_IRQEN = 8'h18;
	localparam logic [7:0] OFF_PREEN = 8'h1c;
	localparam logic [7:0] OFF_DLY0 = 8'h20;
	// control register fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_CONT_BIT = 1;
	localparam int CTRL_LOAD_BIT = 2;
	localparam int CTRL_LMODE_LSB = 3;
	localparam int CTRL_SWTRIG_BIT = 5;
	// status bit positions
	localparam int ST_DLY_BIT = 0;
	localparam int ST_SEQERR_BIT = 1;
	localparam int ST_W = 2;
	// reset values and read data of unmapped addresses
	localparam logic [15:0] MOD_RST = 16'hffff;
	localparam logic [15:0] INTERRUPT_DELAY_VALUE_RST = 16'hffff;
	localparam logic [15:0] DLY_RST = 16'h0000;
	localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;
	// load modes for the double buffers
	typedef enum logic [1:0] {
		LOAD_NOW = 2'h0,
		LOAD_AT_MOD = 2'h1,
		LOAD_AT_TRIG = 2'h2,
		LOAD_AT_MOD_OR_TRIG = 2'h3
	} load_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} run_state_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic [CNT_W-1:0] modulus;
		logic [CNT_W-1:0] interrupt_delay_value;
	} timebase_t;
endpackage

// ### testbench/delay_sched_monitor.sv
// port checker for the delay trigger scheduler
`timescale 1ns/100ps
`default_nettype none
module delay_sched_monitor import delay_sched_pkg::*; #(
	parameter int NPRE = NUM_PRE
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic [NPRE-1:0] conversion_done_flag,
	input wire logic [NPRE-1:0] pretrigger_pulse,
	input wire logic [NPRE-1:0] pretrigger_lock
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	pulse_once_a: assert property (clk_en && pretrigger_pulse[0] |=> !pretrigger_pulse[0])
		else $error("pulse too long");
	pulse_locks_a: assert property (|pretrigger_pulse |-> (pretrigger_pulse & ~pretrigger_lock) == '0)
		else $error("pulse without lock");
	lock_holds_a: assert property (clk_en && pretrigger_lock[0] && !conversion_done_flag[0] |=> pretrigger_lock[0])
		else $error("lock dropped");
	lock_clears_a: assert property (clk_en && pretrigger_lock[1] && conversion_done_flag[1]
		|=> !pretrigger_lock[1] || pretrigger_pulse[1])
		else $error("lock stuck");
	lock_cause_a: assert property ($rose(pretrigger_lock[1]) |-> pretrigger_pulse[1])
		else $error("lock without pulse");
	blocked_hit_a: assert property (clk_en && pretrigger_lock[0] && !conversion_done_flag[0] |=> !pretrigger_pulse[0])
		else $error("pulse while locked");
	rdata_holds_a: assert property (clk_en && !reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	unmapped_zero_a: assert property (clk_en && reg_rd && reg_addr == 8'hfc |=> reg_rdata == RDATA_UNMAPPED)
		else $error("unmapped read data");
endmodule
bind delay_trigger_scheduler delay_sched_monitor #(.NPRE(NPRE)) mon_u (.ref_clk, .rst, .clk_en,
	.reg_addr, .reg_rd, .reg_rdata, .conversion_done_flag, .pretrigger_pulse, .pretrigger_lock);
`default_nettype wire

// ### testbench/pwm_adc_model.sv
// pwm cycle-start source and two converters facing the scheduler
`timescale 1ns/100ps
`default_nettype none
module pwm_adc_model #(
	parameter int PWM_MOD = 4000,
	parameter int CONV = 100
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic trig_en,
	input wire logic stall,
	input wire logic [1:0] pretrigger_pulse,
	output logic cycle_start_trig,
	output logic [1:0] conversion_done_flag
);
	int pwm_cnt;
	int busy [2];
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pwm_cnt <= 0;
			cycle_start_trig <= 1'b0;
			conversion_done_flag <= 2'h0;
			busy <= '{0, 0};
		end else begin
			pwm_cnt <= (pwm_cnt == PWM_MOD - 1) ? 0 : pwm_cnt + 1;
			cycle_start_trig <= trig_en && pwm_cnt == PWM_MOD - 1;
			for (int i = 0; i < 2; i++) begin
				// stall models a converter that never finishes, to block the lock
				conversion_done_flag[i] <= busy[i] == 1 && !stall;
				if (pretrigger_pulse[i]) begin
					busy[i] <= CONV;
				end else if (busy[i] > 1 || (busy[i] == 1 && !stall)) begin
					busy[i] <= busy[i] - 1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench/test_delay_trigger_scheduler.sv
// self-checking bench for the delay trigger scheduler
`timescale 1ns/100ps
`default_nettype none
module test_delay_trigger_scheduler import delay_sched_pkg::*;;
	logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, trig_en = 1'b0, stall = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
	logic cycle_start_trig, irq;
	logic [1:0] conversion_done_flag, pretrigger_pulse, pretrigger_lock;
	int mismatches = 0, tests_run = 0;
	time t0;
	always #5 ref_clk = ~ref_clk;
	delay_trigger_scheduler dut_u (.ref_clk, .rst, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .cycle_start_trig, .conversion_done_flag, .pretrigger_pulse,
		.pretrigger_lock, .irq);
	pwm_adc_model peer_u (.ref_clk, .rst, .trig_en, .stall, .pretrigger_pulse, .cycle_start_trig,
		.conversion_done_flag);
	// ********
	// tasks
	// ********
	task automatic end_sim();
		if (mismatches == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		chk(reg_rdata & m, e);
	endtask
	// channel 2 stands for the interrupt line
	task automatic wait_hi(input int ch);
		int n;
		n = 0;
		while ((ch == 2 ? irq : pretrigger_pulse[ch[0]]) !== 1'b1) begin
			@(posedge ref_clk);
			n++;
			if (n > 6000) begin
				mismatches++;
				end_sim();
			end
		end
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(OFF_MOD, 32'hffff, {16'h0, MOD_RST});
		rd(OFF_INTERRUPT_DELAY_VALUE, 32'hffff, {16'h0, INTERRUPT_DELAY_VALUE_RST});
		rd(OFF_DLY0, 32'hffff, {16'h0, DLY_RST});
		rd(8'hfc, 32'hffff_ffff, RDATA_UNMAPPED);
		wr(OFF_MOD, 32'h1388);
		wr(OFF_INTERRUPT_DELAY_VALUE, 32'h1387);
		wr(OFF_DLY0, 32'h0);
		wr(OFF_DLY0 + 8'h04, 32'h07d0);
		wr(OFF_PREEN, 32'h3);
		wr(OFF_IRQEN, 32'h3);
		wr(OFF_CTRL, 32'h1);
		wr(OFF_CTRL, 32'h5);
		trig_en <= 1'b1;
		wait_hi(0);
		t0 = $time;
		trig_en <= 1'b0;
		wait_hi(1);
		chk(32'(($time - t0) / 10), 32'h7d0);
		chk({30'h0, pretrigger_lock}, 32'h2);
		wait_hi(2);
		chk(32'(($time - t0) / 10), 32'h1387);
		rd(OFF_STATUS, 32'h3, 32'h1);
		rd(OFF_COUNT, 32'hffff, 32'h1388);
		rd(OFF_CTRL, 32'h100, 32'h0);
		wr(OFF_IRQEN, 32'h2);
		chk({31'h0, irq}, 32'h0);
		wr(OFF_CLEAR, 32'h1);
		wr(OFF_IRQEN, 32'h3);
		chk({31'h0, irq}, 32'h0);
		// second software trigger lands while the first conversion is still open
		stall <= 1'b1;
		wr(OFF_CTRL, 32'h21);
		wr(OFF_CTRL, 32'h21);
		repeat (3) @(posedge ref_clk);
		rd(OFF_STATUS, 32'h302, 32'h102);
		chk({31'h0, irq}, 32'h1);
		stall <= 1'b0;
		// the open conversion still needs most of its conversion time before it reports done
		repeat (120) @(posedge ref_clk);
		chk({30'h0, pretrigger_lock}, 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire

// ### verilog/delay_trigger_scheduler.sv
// delay trigger scheduler: counter, pre-trigger sequencing, locks, double buffers, interrupt
`timescale 1ns/100ps
`default_nettype none
module delay_trigger_scheduler
	import delay_sched_pkg::*;
#(
	parameter int NPRE = NUM_PRE
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic cycle_start_trig,
	input wire logic [NPRE-1:0] conversion_done_flag,
	output logic [NPRE-1:0] pretrigger_pulse,
	output logic [NPRE-1:0] pretrigger_lock,
	output logic irq
);
	// ****************************************
	// register bus
	// ****************************************
	reg_req_t req;
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	logic enable_r;
	logic cont_r;
	load_mode_t lmode_r;
	logic load_pend_r;
	timebase_t tb_buf_r;
	timebase_t tb_act_r;
	logic [CNT_W-1:0] dly_buf_r [NPRE];
	logic [CNT_W-1:0] dly_act_r [NPRE];
	logic [NPRE-1:0] pre_en_r;
	logic [ST_W-1:0] status_r;
	logic [ST_W-1:0] irq_en_r;
	logic [CNT_W-1:0] count_r;
	run_state_t state_r;
	run_state_t state_nxt;
	logic trig_d_r;
	logic [NPRE-1:0] fired_r;
	logic [NPRE-1:0] lock_r;
	logic [NPRE-1:0] pulse_r;
	logic [DATA_W-1:0] rdata_r;

	wire wr_ctrl = req.wr && req.addr == OFF_CTRL;
	wire wr_mod = req.wr && req.addr == OFF_MOD;
	wire wr_interrupt_delay_value = req.wr && req.addr == OFF_INTERRUPT_DELAY_VALUE;
	wire wr_clear = req.wr && req.addr == OFF_CLEAR;
	wire wr_irqen = req.wr && req.addr == OFF_IRQEN;
	wire wr_preen = req.wr && req.addr == OFF_PREEN;
	wire [ST_W-1:0] clr_bits = wr_clear ? req.wdata[ST_W-1:0] : '0;

	// ****************************************
	// counter and sequencing
	// ****************************************
	// trigger source runs on ref_clk, so only an edge detector is needed
	wire trig_evt = enable_r && ((cycle_start_trig && !trig_d_r) ||
		(wr_ctrl && req.wdata[CTRL_SWTRIG_BIT]));
	wire running = state_r == ST_RUN;
	wire at_mod = running && count_r == tb_act_r.modulus;
	wire interrupt_delay_value_hit = running && count_r == tb_act_r.interrupt_delay_value;
	wire restart = trig_evt;
	wire load_cmd = wr_ctrl && req.wdata[CTRL_LOAD_BIT] && req.wdata[CTRL_EN_BIT];
	// the load command only takes effect while the block is enabled
	wire do_load = (load_cmd || load_pend_r) && (enable_r || load_cmd) && (
		lmode_r == LOAD_NOW || load_cmd && load_mode_t'(req.wdata[CTRL_LMODE_LSB +: 2]) == LOAD_NOW ||
		(lmode_r == LOAD_AT_MOD && at_mod) ||
		(lmode_r == LOAD_AT_TRIG && trig_evt) ||
		(lmode_r == LOAD_AT_MOD_OR_TRIG && (at_mod || trig_evt)));

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (restart) state_nxt = ST_RUN;
			ST_RUN: if (!enable_r) state_nxt = ST_IDLE;
				else if (at_mod && !cont_r && !restart) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	logic [NPRE-1:0] hit;
	logic [NPRE-1:0] blocked;
	genvar gi;
	generate
		for (gi = 0; gi < NPRE; gi++) begin : g_pre
			// fires once per counting period when the count equals the delay
			assign hit[gi] = running && pre_en_r[gi] && !fired_r[gi] &&
				count_r == dly_act_r[gi];
			assign blocked[gi] = hit[gi] && lock_r[gi];
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					dly_buf_r[gi] <= DLY_RST;
					dly_act_r[gi] <= DLY_RST;
					fired_r[gi] <= 1'b0;
					lock_r[gi] <= 1'b0;
					pulse_r[gi] <= 1'b0;
				end else if (clk_en) begin
					if (req.wr && req.addr == OFF_DLY0 + 8'(4 * gi))
						dly_buf_r[gi] <= req.wdata[CNT_W-1:0];
					if (do_load)
						dly_act_r[gi] <= dly_buf_r[gi];
					if (restart || (at_mod && cont_r))
						fired_r[gi] <= 1'b0;
					else if (hit[gi])
						fired_r[gi] <= 1'b1;
					pulse_r[gi] <= hit[gi] && !lock_r[gi];
					// a new pulse wins over a done report in the same cycle
					if (hit[gi] && !lock_r[gi])
						lock_r[gi] <= 1'b1;
					else if (conversion_done_flag[gi])
						lock_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			count_r <= '0;
			trig_d_r <= 1'b0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			trig_d_r <= cycle_start_trig;
			if (restart || (at_mod && cont_r))
				count_r <= '0;
			else if (running && !at_mod)
				count_r <= count_r + 16'h0001;
		end
	end

	// ****************************************
	// control, buffers and interrupt
	// ****************************************
	wire [ST_W-1:0] evt = {|blocked, interrupt_delay_value_hit};

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			enable_r <= 1'b0;
			cont_r <= 1'b0;
			lmode_r <= LOAD_NOW;
			load_pend_r <= 1'b0;
			tb_buf_r <= '{modulus: MOD_RST, interrupt_delay_value: INTERRUPT_DELAY_VALUE_RST};
			tb_act_r <= '{modulus: MOD_RST, interrupt_delay_value: INTERRUPT_DELAY_VALUE_RST};
			pre_en_r <= '0;
			status_r <= '0;
			irq_en_r <= '0;
		end else if (clk_en) begin
			if (wr_ctrl) begin
				enable_r <= req.wdata[CTRL_EN_BIT];
				cont_r <= req.wdata[CTRL_CONT_BIT];
				lmode_r <= load_mode_t'(req.wdata[CTRL_LMODE_LSB +: 2]);
			end
			if (wr_mod)
				tb_buf_r.modulus <= req.wdata[CNT_W-1:0];
			if (wr_interrupt_delay_value)
				tb_buf_r.interrupt_delay_value <= req.wdata[CNT_W-1:0];
			if (do_load) begin
				tb_act_r <= tb_buf_r;
				load_pend_r <= 1'b0;
			end else if (load_cmd)
				load_pend_r <= 1'b1;
			if (wr_preen)
				pre_en_r <= req.wdata[NPRE-1:0];
			if (wr_irqen)
				irq_en_r <= req.wdata[ST_W-1:0];
			// set wins over clear
			status_r <= (status_r & ~clr_bits) | evt;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = RDATA_UNMAPPED;
		case (req.addr)
			OFF_CTRL: rd_mux = 32'({load_pend_r, lmode_r, 1'b0, cont_r, enable_r}) |
				32'(state_r == ST_RUN) << 8;
			OFF_MOD: rd_mux = 32'(tb_buf_r.modulus);
			OFF_INTERRUPT_DELAY_VALUE: rd_mux = 32'(tb_buf_r.interrupt_delay_value);
			OFF_COUNT: rd_mux = 32'(count_r);
			OFF_STATUS: rd_mux = 32'(status_r) | (32'(lock_r) << 8);
			OFF_IRQEN: rd_mux = 32'(irq_en_r);
			OFF_PREEN: rd_mux = 32'(pre_en_r);
			default: begin
				for (int k = 0; k < NPRE; k++)
					if (req.addr == OFF_DLY0 + 8'(4 * k))
						rd_mux = 32'(dly_buf_r[k]);
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			rdata_r <= '0;
		else if (clk_en && req.rd)
			rdata_r <= rd_mux;
	end

	assign reg_rdata = rdata_r;
	assign pretrigger_pulse = pulse_r;
	assign pretrigger_lock = lock_r;
	assign irq = |(status_r & irq_en_r);
endmodule
`default_nettype wire
